// ===== shared/irq_en_pkg.sv
// shared constants, field layout and mode codes of the enable block
// Notes on behaviour
// - readback returns every current enable bit
// - address 01, select 0 reads feedback
// - no-write flag set keeps enables unchanged
// - no-write flag clear loads frame enables
// - watchdog overflow: interrupt if enabled in standby, else reset
// - overheat threshold crossing interrupts when enabled
// - ground offset crossing interrupts when enabled
// - wrong clock count interrupts, resets in boot
// - wrong count, disabled: access dropped silently
// - battery sense falling edge interrupts when enabled
// - aux supply short interrupts when enabled
// - CAN fault change interrupts when enabled
// - LIN fault change interrupts when enabled
// - wake pin fall interrupts in active modes
// - wake pin fall, disabled, resets in standby
// - CAN wake: interrupt if enabled, else reset
// - LIN wake: interrupt if enabled, else reset
// - watchdog overflow clears its own enable
// - select 1 returns interrupt cause instead
package irq_en_pkg;
	localparam int FRAME_W = 16;
	localparam int EN_W = 12;
	localparam int CNT_W = 5;
	localparam int IDX_W = 4;
	localparam int ADDR_HI = 15;
	localparam int ADDR_LO = 14;
	localparam int RRS_BIT = 13;
	localparam int RO_BIT = 12;
	localparam int WD_BIT = 11;
	localparam int OVERHEAT_BIT = 10;
	localparam int GND_BIT = 9;
	localparam int CLKCNT_BIT = 8;
	localparam int BAT_BIT = 7;
	localparam int AUX_BIT = 6;
	localparam int CANF_BIT = 5;
	localparam int LINF_BIT = 4;
	localparam int WAKE_BIT = 3;
	localparam int RESV_BIT = 2;
	localparam int CANW_BIT = 1;
	localparam int LINW_BIT = 0;
	localparam int PIN_N = 2;
	localparam int PIN_WAKE = 0;
	localparam int PIN_SENSE = 1;
	localparam int LVL_N = 4;
	localparam int LVL_OVERHEAT = 0;
	localparam int LVL_GND = 1;
	localparam int LVL_CANF = 2;
	localparam int LVL_LINF = 3;
	localparam logic [1:0] FEEDBACK_ADDR = 2'h1;
	localparam logic [CNT_W-1:0] FRAME_BITS = 5'h10;
	localparam logic [CNT_W-1:0] CNT_MAX = 5'h1f;
	localparam logic [CNT_W-1:0] RRS_CNT = 5'h02;
	localparam logic [EN_W-1:0] ENABLE_MASK = 12'hffb;
	localparam logic [EN_W-1:0] ENABLE_RESET = 12'h000;
	localparam logic [EN_W-1:0] CAUSE_RESET = 12'h000;
	localparam logic [FRAME_W-EN_W-1:0] WORD_PAD = 4'h0;
	typedef enum logic [2:0] {
		MODE_STARTUP = 3'b000,
		MODE_RESTART = 3'b001,
		MODE_NORMAL = 3'b010,
		MODE_STANDBY = 3'b011,
		MODE_SLEEP = 3'b100,
		MODE_FLASH = 3'b101,
		MODE_FAILSAFE = 3'b110
	} sbc_mode_e;
endpackage

// ===== design/spi_frame_shifter.sv
// serial frame shifter running on the link clock
`timescale 1ns/1ns

module spi_frame_shifter
	import irq_en_pkg::*;
(
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic scs_n,
	input wire logic sdi,
	input wire logic [FRAME_W-1:0] fb_word,
	input wire logic [FRAME_W-1:0] cause_word,
	output logic sdo,
	output logic sdo_oe,
	output logic [FRAME_W-1:0] rx_word,
	output logic [CNT_W-1:0] rx_count,
	output logic frame_tgl
);
	logic armed_r;
	logic rrs_r;
	logic tgl_r;
	logic sdo_r;
	logic [FRAME_W-1:0] rx_r;
	logic [CNT_W-1:0] cnt_r;
	logic [CNT_W-1:0] cnt_now;
	logic [FRAME_W-1:0] tx_word;

	// count restarts on the first edge of each frame, not at select high,
	// so the finished count survives for the other domain to read
	assign cnt_now = armed_r ? cnt_r : {CNT_W{1'b0}};
	assign tx_word = rrs_r ? cause_word : fb_word;

	always_ff @(posedge sclk or posedge scs_n or negedge arst_n) begin
		if (!arst_n)
			armed_r <= 1'b0;
		else if (scs_n)
			armed_r <= 1'b0;
		else
			armed_r <= 1'b1;
	end

	always_ff @(posedge sclk or negedge arst_n) begin
		if (!arst_n) begin
			rx_r <= {FRAME_W{1'b0}};
			cnt_r <= {CNT_W{1'b0}};
			rrs_r <= 1'b0;
			tgl_r <= 1'b0;
		end else begin
			rx_r <= {rx_r[FRAME_W-2:0], sdi};
			if (cnt_now != CNT_MAX)
				cnt_r <= cnt_now + CNT_W'(1);
			if (cnt_now == RRS_CNT)
				rrs_r <= sdi;
			if (!armed_r)
				tgl_r <= ~tgl_r;
		end
	end

	// data changes on the falling edge, host samples on the rising one
	always_ff @(negedge sclk or posedge scs_n) begin
		if (scs_n)
			sdo_r <= 1'b0;
		else if (!cnt_r[CNT_W-1])
			sdo_r <= tx_word[~cnt_r[IDX_W-1:0]];
		else
			sdo_r <= 1'b0;
	end

	assign sdo = sdo_r;
	assign sdo_oe = ~scs_n;
	assign rx_word = rx_r;
	assign rx_count = cnt_r;
	assign frame_tgl = tgl_r;
endmodule

// ===== design/irq_event_front.sv
// pin synchronisers and event edge detectors
`timescale 1ns/1ns

module irq_event_front
	import irq_en_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [PIN_N-1:0] pins,
	input wire logic [LVL_N-1:0] levels,
	output logic [PIN_N-1:0] pin_fall,
	output logic [LVL_N-1:0] level_chg
);
	logic primed_r;

	// first cycle after reset has no valid history to compare with
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			primed_r <= 1'b0;
		else
			primed_r <= 1'b1;
	end

	genvar i;
	generate
		for (i = 0; i < PIN_N; i++) begin : g_pin
			logic meta_r;
			logic sync_r;
			logic prev_r;
			logic fall_r;
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
					prev_r <= 1'b1;
					fall_r <= 1'b0;
				end else begin
					meta_r <= pins[i];
					sync_r <= meta_r;
					prev_r <= sync_r;
					fall_r <= prev_r & ~sync_r;
				end
			end
			assign pin_fall[i] = fall_r;
		end
		for (i = 0; i < LVL_N; i++) begin : g_lvl
			logic prev_r;
			logic chg_r;
			always_ff @(posedge clock or negedge arst_n) begin
				if (!arst_n) begin
					prev_r <= 1'b0;
					chg_r <= 1'b0;
				end else begin
					prev_r <= levels[i];
					chg_r <= primed_r & (levels[i] ^ prev_r);
				end
			end
			assign level_chg[i] = chg_r;
		end
	endgenerate
endmodule

// ===== design/interrupt_enable_readback.sv
// interrupt enable register with serial readback and event routing
`timescale 1ns/1ns

module interrupt_enable_readback
	import irq_en_pkg::*;
(
	input wire logic clock,
	input wire logic arst_n,
	input wire logic sclk,
	input wire logic scs_n,
	input wire logic sdi,
	output logic sdo,
	output logic sdo_oe,
	input wire sbc_mode_e mode,
	input wire logic wd_overflow,
	input wire logic overheat_warn,
	input wire logic gnd_offset_warn,
	input wire logic can_fault_status,
	input wire logic lin_fault_status,
	input wire logic battery_sense_pin,
	input wire logic aux_supply_a_short,
	input wire logic aux_supply_b_short,
	input wire logic wake_pin,
	input wire logic can_wakeup_evt,
	input wire logic lin_wakeup_evt,
	output logic [EN_W-1:0] interrupt_enable_feedback,
	output logic [EN_W-1:0] irq_cause,
	output logic irq_pending,
	output logic reset_req
);
	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [EN_W-1:0] en_r;
	logic [EN_W-1:0] cause_r;
	logic [EN_W-1:0] cause_nxt;
	logic [EN_W-1:0] cause_set;
	logic pending_r;
	logic reset_r;
	logic reset_hit;
	logic [FRAME_W-1:0] fb_word_r;
	logic [FRAME_W-1:0] cause_word_r;
	logic [FRAME_W-1:0] rx_word;
	logic [CNT_W-1:0] rx_count;
	logic frame_tgl;
	logic cs_meta_r;
	logic cs_sync_r;
	logic cs_prev_r;
	logic tgl_meta_r;
	logic tgl_sync_r;
	logic tgl_seen_r;
	logic frame_end;
	logic edges_seen;
	logic count_ok;
	logic addr_hit;
	logic rrs_sel;
	logic no_write_flag;
	logic access_ok;
	logic enable_write;
	logic cause_read;
	logic count_fail;
	logic [EN_W-1:0] rx_enables;
	logic mode_standby;
	logic mode_boot;
	logic mode_wake_ok;
	logic [PIN_N-1:0] pin_fall;
	logic [LVL_N-1:0] level_chg;
	logic wake_fall;
	logic sense_fall;
	logic overheat_chg;
	logic gnd_chg;
	logic canf_chg;
	logic linf_chg;

	// ----------------------------------------------------------------
	// link side
	// ----------------------------------------------------------------
	spi_frame_shifter u_shifter (
		.arst_n(arst_n),
		.sclk(sclk),
		.scs_n(scs_n),
		.sdi(sdi),
		.fb_word(fb_word_r),
		.cause_word(cause_word_r),
		.sdo(sdo),
		.sdo_oe(sdo_oe),
		.rx_word(rx_word),
		.rx_count(rx_count),
		.frame_tgl(frame_tgl)
	);

	// ----------------------------------------------------------------
	// event front end
	// ----------------------------------------------------------------
	irq_event_front u_front (
		.clock(clock),
		.arst_n(arst_n),
		.pins({battery_sense_pin, wake_pin}),
		.levels({lin_fault_status, can_fault_status,
			gnd_offset_warn, overheat_warn}),
		.pin_fall(pin_fall),
		.level_chg(level_chg)
	);

	assign wake_fall = pin_fall[PIN_WAKE];
	assign sense_fall = pin_fall[PIN_SENSE];
	assign overheat_chg = level_chg[LVL_OVERHEAT];
	assign gnd_chg = level_chg[LVL_GND];
	assign canf_chg = level_chg[LVL_CANF];
	assign linf_chg = level_chg[LVL_LINF];

	// ----------------------------------------------------------------
	// frame crossing
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cs_meta_r <= 1'b1;
			cs_sync_r <= 1'b1;
			cs_prev_r <= 1'b1;
		end else begin
			cs_meta_r <= scs_n;
			cs_sync_r <= cs_meta_r;
			cs_prev_r <= cs_sync_r;
		end
	end

	// toggle tells a frame with no clock edges from a stale count
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tgl_meta_r <= 1'b0;
			tgl_sync_r <= 1'b0;
			tgl_seen_r <= 1'b0;
		end else begin
			tgl_meta_r <= frame_tgl;
			tgl_sync_r <= tgl_meta_r;
			if (frame_end)
				tgl_seen_r <= tgl_sync_r;
		end
	end

	// shifter outputs are quiet while select is high, so reading the
	// word and count after the synchronised rise is safe
	assign frame_end = cs_sync_r & ~cs_prev_r;
	assign edges_seen = tgl_sync_r ^ tgl_seen_r;
	assign count_ok = edges_seen && (rx_count == FRAME_BITS);
	assign addr_hit = rx_word[ADDR_HI:ADDR_LO] == FEEDBACK_ADDR;
	assign rrs_sel = rx_word[RRS_BIT];
	assign no_write_flag = rx_word[RO_BIT];
	assign access_ok = frame_end && count_ok && addr_hit;
	assign enable_write = access_ok && !no_write_flag;
	assign cause_read = access_ok && rrs_sel;
	assign count_fail = frame_end && !count_ok;
	assign rx_enables = rx_word[EN_W-1:0] & ENABLE_MASK;

	// ----------------------------------------------------------------
	// readback snapshot
	// ----------------------------------------------------------------
	// frozen during a frame: the old settings go out while the new ones
	// are shifted in
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fb_word_r <= {WORD_PAD, ENABLE_RESET};
			cause_word_r <= {WORD_PAD, CAUSE_RESET};
		end else if (cs_sync_r) begin
			fb_word_r <= {WORD_PAD, en_r};
			cause_word_r <= {WORD_PAD, cause_r};
		end
	end

	// ----------------------------------------------------------------
	// enable register
	// ----------------------------------------------------------------
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			en_r <= ENABLE_RESET;
		end else begin
			if (enable_write)
				en_r <= rx_enables;
			// overflow clears even when a write lands in the same cycle
			if (wd_overflow)
				en_r[WD_BIT] <= 1'b0;
		end
	end

	// ----------------------------------------------------------------
	// event routing
	// ----------------------------------------------------------------
	assign mode_standby = mode == MODE_STANDBY;
	assign mode_boot = (mode == MODE_STARTUP) || (mode == MODE_RESTART);
	assign mode_wake_ok = (mode == MODE_NORMAL) || (mode == MODE_FLASH)
		|| mode_standby;

	always_comb begin
		cause_set = {EN_W{1'b0}};
		reset_hit = 1'b0;
		if (wd_overflow) begin
			if (mode_standby && en_r[WD_BIT])
				cause_set[WD_BIT] = 1'b1;
			else
				reset_hit = 1'b1;
		end
		cause_set[OVERHEAT_BIT] = overheat_chg && en_r[OVERHEAT_BIT];
		cause_set[GND_BIT] = gnd_chg && en_r[GND_BIT];
		if (count_fail && en_r[CLKCNT_BIT]) begin
			if (mode_boot)
				reset_hit = 1'b1;
			else
				cause_set[CLKCNT_BIT] = 1'b1;
		end
		cause_set[BAT_BIT] = sense_fall && en_r[BAT_BIT];
		cause_set[AUX_BIT] = (aux_supply_a_short || aux_supply_b_short)
			&& en_r[AUX_BIT];
		cause_set[CANF_BIT] = canf_chg && en_r[CANF_BIT];
		cause_set[LINF_BIT] = linf_chg && en_r[LINF_BIT];
		if (wake_fall) begin
			if (en_r[WAKE_BIT])
				cause_set[WAKE_BIT] = mode_wake_ok;
			else if (mode_standby)
				reset_hit = 1'b1;
		end
		if (can_wakeup_evt) begin
			if (en_r[CANW_BIT])
				cause_set[CANW_BIT] = 1'b1;
			else
				reset_hit = 1'b1;
		end
		if (lin_wakeup_evt) begin
			if (en_r[LINW_BIT])
				cause_set[LINW_BIT] = 1'b1;
			else
				reset_hit = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// cause register
	// ----------------------------------------------------------------
	// a read clears only what was shown, and new events win over the
	// clear, so nothing that arrives during a frame is lost
	always_comb begin
		cause_nxt = cause_r;
		if (cause_read)
			cause_nxt = cause_r & ~cause_word_r[EN_W-1:0];
		cause_nxt = cause_nxt | cause_set;
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cause_r <= CAUSE_RESET;
			pending_r <= 1'b0;
		end else begin
			cause_r <= cause_nxt;
			pending_r <= |cause_nxt;
		end
	end

	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n)
			reset_r <= 1'b0;
		else
			reset_r <= reset_hit;
	end

	assign interrupt_enable_feedback = en_r;
	assign irq_cause = cause_r;
	assign irq_pending = pending_r;
	assign reset_req = reset_r;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	fb_snap_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		cs_sync_r |=> fb_word_r == {WORD_PAD, $past(en_r)})
		else $error("feedback snapshot does not follow enables");

	addr_miss_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		frame_end && !addr_hit && !wd_overflow |=> $stable(en_r))
		else $error("enables changed by foreign address");

	ro_hold_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		frame_end && no_write_flag && !wd_overflow |=> $stable(en_r))
		else $error("enables changed by read-only access");

	en_load_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		enable_write && !wd_overflow |=> en_r == $past(rx_enables))
		else $error("enables not loaded from frame");

	wd_route_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		wd_overflow && !(mode_standby && en_r[WD_BIT])
		|=> reset_req ##1 !reset_req || $past(reset_hit))
		else $error("watchdog overflow did not request reset");

	wd_irq_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		wd_overflow && mode_standby && en_r[WD_BIT]
		|=> irq_cause[WD_BIT] && !en_r[WD_BIT] ##1 irq_pending)
		else $error("watchdog interrupt not raised");

	wd_clear_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		wd_overflow |=> !en_r[WD_BIT])
		else $error("watchdog enable not cleared on overflow");

	overheat_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		$rose(overheat_warn) && en_r[OVERHEAT_BIT]
		&& !wd_overflow && !frame_end ##1 $stable(en_r)
		|=> irq_cause[OVERHEAT_BIT])
		else $error("overheat crossing not flagged");

	clk_fail_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		count_fail && en_r[CLKCNT_BIT] && !mode_boot
		|=> irq_cause[CLKCNT_BIT] && $stable(en_r[CANW_BIT]))
		else $error("clock count failure not flagged");

	clk_drop_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		count_fail && !en_r[CLKCNT_BIT] && !wd_overflow
		|=> $stable(en_r) && $stable(irq_cause[CLKCNT_BIT]))
		else $error("bad clock count frame not discarded");

	wake_rst_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		wake_fall && !en_r[WAKE_BIT] && mode_standby
		|=> reset_req && !irq_cause[WAKE_BIT] || $past(cause_r[WAKE_BIT]))
		else $error("wake edge in standby did not reset");

	can_wake_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		can_wakeup_evt && !en_r[CANW_BIT] |=> reset_req)
		else $error("CAN wake did not request reset");

	resv_zero_a: assert property (@(posedge clock)
		disable iff (!arst_n)
		!en_r[RESV_BIT] && !fb_word_r[RESV_BIT])
		else $error("reserved enable bit reads one");
endmodule

// ===== tb/spi_host_model.sv
// host-side serial master that frames words into the device
`timescale 1ns/1ns

module spi_host_model
	import irq_en_pkg::*;
(
	output logic sclk,
	output logic scs_n,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		sclk = 1'b0;
		scs_n = 1'b1;
		sdi = 1'b0;
	end

	// --------------------------------------------------------------
	// frame transfer
	// --------------------------------------------------------------
	// n other than 16 and a set reserved bit are deliberate faults
	task automatic xfer(input logic [15:0] w, input int n,
		input logic keep_resv, output logic [15:0] r);
		if (!keep_resv) begin
			w[RESV_BIT] = 1'b0;
		end
		r = 16'h0000;
		scs_n = 1'b0;
		// snapshot needs three device clocks before the first edge
		#200;
		for (int i = 0; i < n; i++) begin
			sdi = (i < 16) ? w[15 - i] : ~sdi;
			#24;
			sclk = 1'b1;
			r = {r[14:0], sdo};
			#24;
			sclk = 1'b0;
		end
		#200;
		scs_n = 1'b1;
		// released line shows the inverse, never a stale bit
		sdi = ~sdi;
		#250;
	endtask
endmodule

// ===== tb/interrupt_enable_readback_tb_top.sv
// self-checking bench for the enable register and event routing
`timescale 1ns/1ns

module interrupt_enable_readback_tb_top;
	import irq_en_pkg::*;
	logic clock, arst_n, sclk, scs_n, sdi, sdo, sdo_oe;
	sbc_mode_e mode;
	logic wd_overflow, overheat_warn, gnd_offset_warn;
	logic can_fault_status, lin_fault_status, battery_sense_pin;
	logic aux_supply_a_short, aux_supply_b_short, wake_pin;
	logic can_wakeup_evt, lin_wakeup_evt, irq_pending, reset_req;
	logic [EN_W-1:0] interrupt_enable_feedback, irq_cause, v, c, e;
	logic [15:0] rx;
	logic [31:0] seed;
	int miscompares, checks, resets, r0, rexp;
	localparam int bit_of [12] = '{WD_BIT, OVERHEAT_BIT, GND_BIT,
		BAT_BIT, AUX_BIT, AUX_BIT, CANF_BIT, LINF_BIT, WAKE_BIT,
		CANW_BIT, LINW_BIT, CLKCNT_BIT};

	interrupt_enable_readback uut (.clock, .arst_n, .sclk, .scs_n,
		.sdi, .sdo, .sdo_oe, .mode, .wd_overflow, .overheat_warn,
		.gnd_offset_warn, .can_fault_status, .lin_fault_status,
		.battery_sense_pin, .aux_supply_a_short, .aux_supply_b_short,
		.wake_pin, .can_wakeup_evt, .lin_wakeup_evt,
		.interrupt_enable_feedback, .irq_cause, .irq_pending,
		.reset_req);
	spi_host_model host (.sclk, .scs_n, .sdi, .sdo);

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	always @(posedge clock) if (reset_req === 1'b1) resets <= resets + 1;

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic finish_test();
		$display("checks=%0d miscompares=%0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
	endtask

	// wake only in the active modes, overflow interrupt only in
	// standby, count failure everywhere but the boot modes
	function automatic logic [11:0] mode_cause(input int m);
		logic [11:0] x;
		x = 12'h100;
		if (m inside {MODE_STARTUP, MODE_RESTART})
			x = 12'h000;
		if (m inside {MODE_NORMAL, MODE_FLASH, MODE_STANDBY})
			x[WAKE_BIT] = 1'b1;
		if (m == MODE_STANDBY)
			x[WD_BIT] = 1'b1;
		return x;
	endfunction

	// off the clock edge so the select never lands on a sampling step
	task automatic frame(input logic [15:0] w, input int n,
		input logic resv);
		#10;
		host.xfer(w, n, resv, rx);
	endtask

	task automatic fire(input int k);
		@(posedge clock);
		case (k)
		0: wd_overflow <= 1'b1;
		1: overheat_warn <= ~overheat_warn;
		2: gnd_offset_warn <= ~gnd_offset_warn;
		3: battery_sense_pin <= 1'b0;
		4: aux_supply_a_short <= 1'b1;
		5: aux_supply_b_short <= 1'b1;
		6: can_fault_status <= ~can_fault_status;
		7: lin_fault_status <= ~lin_fault_status;
		8: wake_pin <= 1'b0;
		9: can_wakeup_evt <= 1'b1;
		10: lin_wakeup_evt <= 1'b1;
		default: frame(16'h4000, 15, 1'b0);
		endcase
		@(posedge clock);
		wd_overflow <= 1'b0;
		aux_supply_a_short <= 1'b0;
		aux_supply_b_short <= 1'b0;
		can_wakeup_evt <= 1'b0;
		lin_wakeup_evt <= 1'b0;
		cyc(6);
		battery_sense_pin <= 1'b1;
		wake_pin <= 1'b1;
	endtask

	initial begin
		#1_000_000;
		miscompares++;
		finish_test();
	end

	// --------------------------------------------------------------
	// main sequence
	// --------------------------------------------------------------
	initial begin
		seed = 32'h0000_002d;
		{wd_overflow, overheat_warn, gnd_offset_warn} = 3'h0;
		{can_fault_status, lin_fault_status} = 2'h0;
		{aux_supply_a_short, aux_supply_b_short} = 2'h0;
		{can_wakeup_evt, lin_wakeup_evt} = 2'h0;
		battery_sense_pin = 1'b1;
		wake_pin = 1'b1;
		mode = MODE_NORMAL;
		arst_n = 1'b0;
		cyc(2);
		arst_n <= 1'b1;
		cyc(3);
		#5;
		check(16'(interrupt_enable_feedback), 16'h0000);
		check({irq_pending, sdo_oe, 2'h0, irq_cause}, 16'h0000);
		// random writes: each frame returns what the last one wrote
		e = 12'h000;
		for (int i = 0; i < 6; i++) begin
			v = 12'(rnd()) & ENABLE_MASK;
			frame({4'h4, v}, 16, 1'b0);
			check(rx, {4'h0, e});
			e = v;
			check(16'(interrupt_enable_feedback), 16'(e));
		end
		// output enable looked at while the select is low
		fork
			frame({4'h5, ~e}, 16, 1'b0);
			begin
				#300;
				check(16'(sdo_oe), 16'h0001);
			end
		join
		check(rx, {4'h0, e});
		check(16'(interrupt_enable_feedback), 16'(e));
		frame({4'h8, ~e}, 16, 1'b0);
		check(16'(interrupt_enable_feedback), 16'(e));
		frame({4'h4, 12'hfff}, 16, 1'b1);
		check(16'(interrupt_enable_feedback), 16'h0ffb);
		frame({4'h5, 12'h000}, 16, 1'b0);
		check(rx, 16'h0ffb);
		// every event enabled then disabled, all in standby
		for (int k = 0; k < 12; k++) begin
			for (int en = 1; en >= 0; en--) begin
				@(posedge clock);
				mode <= MODE_STANDBY;
				v = (en == 1) ? 12'hffb : 12'h000;
				frame({4'h4, v}, 16, 1'b0);
				r0 = resets;
				fire(k);
				cyc(8);
				#5;
				c = (en == 1) ? (12'h001 << bit_of[k]) : 12'h000;
				e = (k == 0) ? (v & 12'h7ff) : v;
				check(16'(irq_cause), 16'(c));
				check(16'(irq_pending), 16'(|c));
				rexp = int'(en == 0 && k inside {[8:10], 0});
				check(16'(resets - r0), 16'(rexp));
				check(16'(interrupt_enable_feedback), 16'(e));
				frame({4'h7, 12'h000}, 16, 1'b0);
				check(rx, {4'h0, c});
				check(16'(irq_cause), 16'h0000);
			end
		end
		// bad count during start-up asks for a reset instead
		@(posedge clock);
		mode <= MODE_STARTUP;
		frame({4'h4, 12'hffb}, 16, 1'b0);
		r0 = resets;
		fire(11);
		cyc(4);
		#5;
		check(16'(resets - r0), 16'h0001);
		check(16'(irq_cause), 16'h0000);
		check(16'(interrupt_enable_feedback), 16'h0ffb);
		// every mode code: wake fall, overflow, then a short frame
		for (int m = 0; m < 7; m++) begin
			@(posedge clock);
			mode <= sbc_mode_e'(m);
			frame({4'h4, 12'hffb}, 16, 1'b0);
			r0 = resets;
			fire(8);
			fire(0);
			fire(11);
			cyc(8);
			#5;
			c = mode_cause(m);
			rexp = int'(m != MODE_STANDBY)
				+ int'(m inside {MODE_STARTUP, MODE_RESTART});
			check(16'(irq_cause), 16'(c));
			check(16'(resets - r0), 16'(rexp));
			check(16'(interrupt_enable_feedback), 16'h07fb);
			frame({4'h7, 12'h000}, 16, 1'b0);
			check(rx, {4'h0, c});
		end
		finish_test();
	end
endmodule
